// ==== rtl/see_pkg.sv ====
// Constants, types and helpers for the SPI serial EEPROM slave
// Function
// RULE_01: Link works in SPI mode 0 and mode 3; clock idles low or high.
// RULE_02: Input sampled on rising clock edges, output shifted on falling edges.
// RULE_03: Every byte on the link moves most significant bit first.
// RULE_04: Array holds 1,024 bytes arranged as 32-byte pages.
// RULE_05: Single-byte, partial-page and full-page writes up to 32 bytes accepted.
// RULE_06: After a write frame the array is programmed internally within 5 ms.
// RULE_07: User may protect a quarter, a half or all of the array.
// RULE_08: Below power-on threshold nothing is obeyed; above it device resets to standby.
// RULE_09: When supply drops below the threshold the device returns to standby.
// RULE_10: Host starts each instruction by lowering select only when ready.
// RULE_11: Select rising ends the frame and starts programming if a write arrived.
// RULE_12: Standby follows select rising, or follows the end of programming.
// RULE_13: Serial output is high impedance in standby.
// RULE_14: First byte after select falls is the instruction; only valid codes decode.
// RULE_15: During power-up the host keeps select following supply, deselecting device.
// RULE_16: Hardware protection holds only while protect pin low and enable bit one.
// RULE_17: Under hardware protection block-protect and protect-enable bits cannot change.
// RULE_18: Suspend input pauses a sequence; release resumes it where it stopped.
// RULE_19: Six eight-bit codes decoded with bit 3 ignored.
// RULE_20: Status bit 0 reads one while busy; only status read accepted then.
// RULE_21: Write-enable clears after disable, status write or array write.
// RULE_22: Block-protect bits select none, 300h-3FFh, 200h-3FFh or whole array.
// RULE_23: Multi-byte writes wrap within the current 32-byte page.
package see_pkg;
    localparam int ADDR_W = 10;
    localparam int MEM_BYTES = 1024;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] OPC_UPPER = 4'h0;
    localparam logic [2:0] OPC_SET_WE = 3'h6;
    localparam logic [2:0] OPC_CLR_WE = 3'h4;
    localparam logic [2:0] OPC_RD_STAT = 3'h5;
    localparam logic [2:0] OPC_WR_STAT = 3'h1;
    localparam logic [2:0] OPC_READ = 3'h3;
    localparam logic [2:0] OPC_WRITE = 3'h2;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [9:0] PROT_QUARTER_BASE = 10'h300;
    localparam logic [9:0] PROT_HALF_BASE = 10'h200;
    localparam logic [7:0] STAT_BUSY_ALL = 8'hff;
    localparam int STAT_HWPE_BIT = 7;
    localparam int STAT_BP_HI_BIT = 3;
    localparam int STAT_BP_LO_BIT = 2;
    localparam int T_WRITE_MS = 5;
    localparam int CLK_KHZ = 40000;
    localparam int WRITE_CYC = T_WRITE_MS * CLK_KHZ;
    localparam int CNT_W = 18;

    typedef enum {CMD_NONE, CMD_SET_WE, CMD_CLR_WE, CMD_RD_STAT, CMD_WR_STAT,
                  CMD_READ, CMD_WRITE} see_cmd_t;
    typedef enum {PH_OPC, PH_ADDR, PH_DATA, PH_SKIP} see_phase_t;
    typedef enum {ST_IDLE, ST_PROG} see_state_t;

    typedef struct packed {
        logic hw_protect_enable;
        logic [2:0] spare;
        logic block_protect_hi;
        logic block_protect_lo;
        logic write_enable;
        logic busy;
    } see_status_t;

    function automatic see_cmd_t see_decode(input logic [7:0] opc);
        see_cmd_t c;
        c = CMD_NONE;
        if (opc[7:4] == OPC_UPPER) begin
            case (opc[2:0])
                OPC_SET_WE: c = CMD_SET_WE;
                OPC_CLR_WE: c = CMD_CLR_WE;
                OPC_RD_STAT: c = CMD_RD_STAT;
                OPC_WR_STAT: c = CMD_WR_STAT;
                OPC_READ: c = CMD_READ;
                OPC_WRITE: c = CMD_WRITE;
                default: c = CMD_NONE;
            endcase
        end
        return c;
    endfunction

    function automatic logic see_protected(input logic [1:0] bp, input logic [9:0] a);
        logic p;
        p = 1'b1;
        if (bp == BP_NONE) begin
            p = 1'b0;
        end else if (bp == BP_QUARTER) begin
            p = (a >= PROT_QUARTER_BASE);
        end else if (bp == BP_HALF) begin
            p = (a >= PROT_HALF_BASE);
        end
        return p;
    endfunction
endpackage

// ==== rtl/see_eeprom_slave.sv ====
// SPI serial EEPROM slave: link front end on the serial clock, array and write engine on clk
`timescale 1ns/1ps
`default_nettype none
module see_eeprom_slave
    import see_pkg::*;
#(
    parameter int WRITE_CYC_P = WRITE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe_n,
    output see_status_t status
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

    see_status_t stat_ff;
    see_status_t stat_s1_ff, stat_s2_ff;
    logic [7:0] mem_ff [0:MEM_BYTES-1];
    logic [7:0] buf_ff [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] mask_ff;
    logic frame_rst, busy_lk;
    logic [2:0] bit_cnt_ff;
    logic [7:0] shift_ff, rx_byte;
    logic byte_end;
    see_phase_t phase_ff;
    logic addr_hi_ff;
    see_cmd_t rx_cmd;
    see_cmd_t cmd_ff;
    logic cmd_ok_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [PAGE_W-1:0] wr_ptr_ff;
    logic [7:0] wr_stat_ff;
    logic [7:0] tx_shift_ff;
    logic tx_on_ff;
    logic [ADDR_W-1:0] rd_addr_ff;
    logic so_ff, so_en_ff;
    logic cs_s1_ff, cs_s2_ff, cs_d_ff;
    logic wp_s1_ff, wp_s2_ff;
    logic cs_rise, hw_prot, exec;
    see_state_t state_ff;
    logic [CNT_W-1:0] prog_cnt_ff;
    logic prog_arr_ff;
    logic [PAGE_W-1:0] page_ff;
    logic wen_ff, hwpe_ff;
    logic [1:0] bp_ff;
    logic [PAGE_W-1:0] cp_idx;
    logic [ADDR_W-1:0] mem_wa;
    logic mem_we, prog_last;
    see_status_t nxt_stat;

////////////////////////////////////////////////////////////////////////////////
// Link side: serial clock domain

    // The frame state restarts whenever select is high; power-on reset also clears it
    assign frame_rst = rst | cs_n; // RULE_08 RULE_12
    assign rx_byte = {shift_ff[6:0], si}; // RULE_03
    assign byte_end = (bit_cnt_ff == BIT_LAST);
    assign rx_cmd = see_decode(rx_byte); // RULE_14 RULE_19
    assign busy_lk = stat_s2_ff.busy;

    // Status word is quasi-static; it only changes while no write frame runs
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            stat_s1_ff <= '0;
            stat_s2_ff <= '0;
        end else begin
            stat_s1_ff <= stat_ff;
            stat_s2_ff <= stat_s1_ff;
        end
    end

    // Bit counter and phase; suspend freezes everything in place
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_ff <= BIT_FIRST;
            shift_ff <= '0;
            phase_ff <= PH_OPC;
            addr_hi_ff <= 1'b1;
        end else if (hold_n) begin // RULE_18
            bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1); // RULE_02
            shift_ff <= rx_byte;
            if (byte_end) begin
                case (phase_ff)
                    PH_OPC: begin
                        if (busy_lk && rx_cmd != CMD_RD_STAT) begin
                            phase_ff <= PH_SKIP; // RULE_20
                        end else if (rx_cmd == CMD_READ || rx_cmd == CMD_WRITE) begin
                            phase_ff <= PH_ADDR;
                        end else if (rx_cmd == CMD_RD_STAT || rx_cmd == CMD_WR_STAT) begin
                            phase_ff <= PH_DATA;
                        end else begin
                            phase_ff <= PH_SKIP;
                        end
                    end
                    PH_ADDR: begin
                        addr_hi_ff <= 1'b0;
                        if (!addr_hi_ff) begin
                            phase_ff <= PH_DATA;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Captured command survives select rising so the write engine can pick it up
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            cmd_ff <= CMD_NONE;
            cmd_ok_ff <= 1'b0;
            addr_ff <= '0;
            wr_ptr_ff <= '0;
            wr_stat_ff <= '0;
            mask_ff <= '0;
        end else if (hold_n && !cs_n) begin
            if (phase_ff == PH_OPC && bit_cnt_ff == BIT_FIRST) begin
                cmd_ok_ff <= 1'b0;
            end
            if (byte_end) begin
                case (phase_ff)
                    PH_OPC: begin
                        cmd_ff <= (busy_lk && rx_cmd != CMD_RD_STAT) ? CMD_NONE : rx_cmd;
                        cmd_ok_ff <= !busy_lk &&
                                     (rx_cmd == CMD_SET_WE || rx_cmd == CMD_CLR_WE);
                        if (!busy_lk && rx_cmd == CMD_WRITE) begin
                            mask_ff <= '0;
                        end
                    end
                    PH_ADDR: begin
                        if (addr_hi_ff) begin
                            addr_ff[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
                        end else begin
                            addr_ff[7:0] <= rx_byte;
                            wr_ptr_ff <= rx_byte[PAGE_W-1:0];
                        end
                    end
                    PH_DATA: begin
                        if (cmd_ff == CMD_WR_STAT) begin
                            wr_stat_ff <= rx_byte;
                            cmd_ok_ff <= 1'b1;
                        end else if (cmd_ff == CMD_WRITE) begin
                            mask_ff[wr_ptr_ff] <= 1'b1; // RULE_05
                            wr_ptr_ff <= 5'(wr_ptr_ff + 5'h1); // RULE_23
                            cmd_ok_ff <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (phase_ff == PH_DATA && cmd_ff != CMD_RD_STAT) begin
                // A trailing partial byte aborts the whole write
                cmd_ok_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sck) begin
        if (hold_n && !cs_n && byte_end && phase_ff == PH_DATA && cmd_ff == CMD_WRITE) begin
            buf_ff[wr_ptr_ff] <= rx_byte;
        end
    end

    // Output shifter; array is read across domains only while no write runs
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_shift_ff <= '0;
            tx_on_ff <= 1'b0;
            rd_addr_ff <= '0;
        end else if (hold_n) begin
            if (byte_end && phase_ff == PH_OPC && rx_cmd == CMD_RD_STAT) begin
                tx_shift_ff <= stat_s2_ff;
                tx_on_ff <= 1'b1;
            end else if (byte_end && phase_ff == PH_ADDR && !addr_hi_ff
                         && cmd_ff == CMD_READ) begin
                tx_shift_ff <= mem_ff[{addr_ff[ADDR_W-1:8], rx_byte}];
                rd_addr_ff <= 10'({addr_ff[ADDR_W-1:8], rx_byte} + 10'h1);
                tx_on_ff <= 1'b1;
            end else if (tx_on_ff && byte_end) begin
                if (cmd_ff == CMD_RD_STAT) begin
                    tx_shift_ff <= stat_s2_ff;
                end else begin
                    tx_shift_ff <= mem_ff[rd_addr_ff];
                    rd_addr_ff <= 10'(rd_addr_ff + 10'h1);
                end
            end else if (tx_on_ff) begin
                tx_shift_ff <= {tx_shift_ff[6:0], 1'b0}; // RULE_03
            end
        end
    end

    // Falling edge launches the bit so it is stable at the host's rising edge
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            so_ff <= 1'b0;
            so_en_ff <= 1'b0;
        end else if (hold_n) begin
            so_ff <= tx_shift_ff[7]; // RULE_02 RULE_01
            so_en_ff <= tx_on_ff;
        end
    end

    assign so = so_ff;
    assign so_oe_n = ~(so_en_ff & hold_n & ~cs_n & ~rst); // RULE_13 RULE_18 RULE_09

////////////////////////////////////////////////////////////////////////////////
// Core side: clk domain

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_d_ff <= 1'b1;
            wp_s1_ff <= 1'b1;
            wp_s2_ff <= 1'b1;
        end else begin
            cs_s1_ff <= cs_n;
            cs_s2_ff <= cs_s1_ff;
            cs_d_ff <= cs_s2_ff;
            wp_s1_ff <= wp_n;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    // Serial clock has stopped by the time select rising is seen, so the
    // captured command is stable when sampled here
    assign cs_rise = cs_s2_ff & ~cs_d_ff; // RULE_11
    assign exec = (state_ff == ST_IDLE) && cs_rise && cmd_ok_ff;
    assign hw_prot = ~wp_s2_ff & hwpe_ff; // RULE_16
    assign prog_last = (prog_cnt_ff == CNT_W'(WRITE_CYC_P - 1));

    // Write engine: copies the page during the first cycles, then waits out the time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE; // RULE_08
            prog_cnt_ff <= '0;
            prog_arr_ff <= 1'b0;
            page_ff <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    prog_cnt_ff <= '0;
                    if (exec && wen_ff &&
                        (cmd_ff == CMD_WRITE || cmd_ff == CMD_WR_STAT)) begin
                        state_ff <= ST_PROG; // RULE_11 RULE_06
                        prog_arr_ff <= (cmd_ff == CMD_WRITE);
                        page_ff <= addr_ff[ADDR_W-1:PAGE_W];
                    end
                end
                ST_PROG: begin
                    prog_cnt_ff <= CNT_W'(prog_cnt_ff + 1'b1);
                    if (prog_last) begin
                        state_ff <= ST_IDLE; // RULE_06 RULE_12
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Status bits; write-enable and protection settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wen_ff <= 1'b0;
            bp_ff <= BP_NONE;
            hwpe_ff <= 1'b0;
        end else if (exec) begin
            case (cmd_ff)
                CMD_SET_WE: wen_ff <= 1'b1;
                CMD_CLR_WE: wen_ff <= 1'b0; // RULE_21
                CMD_WR_STAT: begin
                    wen_ff <= 1'b0; // RULE_21
                    if (wen_ff && !hw_prot) begin // RULE_17
                        bp_ff <= {wr_stat_ff[STAT_BP_HI_BIT], wr_stat_ff[STAT_BP_LO_BIT]};
                        hwpe_ff <= wr_stat_ff[STAT_HWPE_BIT];
                    end
                end
                CMD_WRITE: wen_ff <= 1'b0; // RULE_21
                default: begin
                end
            endcase
        end
    end

    // Masked bytes only: a partial page leaves the rest of the page untouched
    assign cp_idx = prog_cnt_ff[PAGE_W-1:0];
    assign mem_wa = {page_ff, cp_idx}; // RULE_04 RULE_23
    assign mem_we = (state_ff == ST_PROG) && prog_arr_ff &&
                    (prog_cnt_ff < CNT_W'(PAGE_BYTES)) && mask_ff[cp_idx] &&
                    !see_protected(bp_ff, mem_wa); // RULE_07 RULE_22

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_ff[mem_wa] <= buf_ff[cp_idx]; // RULE_05
        end
    end

    always_comb begin
        nxt_stat = '0;
        nxt_stat.hw_protect_enable = hwpe_ff;
        nxt_stat.block_protect_hi = bp_ff[1];
        nxt_stat.block_protect_lo = bp_ff[0];
        nxt_stat.write_enable = wen_ff;
        if (state_ff == ST_PROG) begin
            nxt_stat = see_status_t'(STAT_BUSY_ALL); // RULE_20
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign status = stat_ff;

////////////////////////////////////////////////////////////////////////////////
// Checks

    AST_WRITE_STARTS: assert property (@(posedge clk) disable iff (rst) // RULE_11
        (exec && wen_ff && cmd_ff == CMD_WRITE) |=> (state_ff == ST_PROG) ##1 status.busy)
        else $error("write frame did not start programming");
    AST_PROG_BOUND: assert property (@(posedge clk) disable iff (rst) // RULE_06
        (state_ff == ST_PROG) |-> (prog_cnt_ff < CNT_W'(WRITE_CYC_P)))
        else $error("programming ran past its time");
    AST_PROG_ENDS: assert property (@(posedge clk) disable iff (rst) // RULE_12
        (state_ff == ST_PROG && prog_last) |=> (state_ff == ST_IDLE) ##1 !status.busy)
        else $error("device did not return to standby after programming");
    AST_WEN_CLEARED: assert property (@(posedge clk) disable iff (rst) // RULE_21
        (exec && cmd_ff != CMD_SET_WE && cmd_ff != CMD_NONE && cmd_ff != CMD_RD_STAT
         && cmd_ff != CMD_READ) |=> !wen_ff)
        else $error("write enable not cleared");
    AST_HW_LOCK: assert property (@(posedge clk) disable iff (rst) // RULE_17
        (hw_prot && exec) |=> ($stable(bp_ff) && $stable(hwpe_ff)))
        else $error("protection bits changed under hardware protection");
    AST_BUSY_IGNORES: assert property (@(posedge clk) disable iff (rst) // RULE_20
        (state_ff == ST_PROG) ##1 (state_ff == ST_PROG) |-> $stable(wen_ff))
        else $error("command obeyed while busy");
    // The link side must disarm any frame that ends while programming runs
    AST_BUSY_DROPS: assert property (@(posedge clk) disable iff (rst) // RULE_20
        (state_ff == ST_PROG && cs_rise) |-> !cmd_ok_ff)
        else $error("command armed by a frame sent while busy");
    AST_NO_PROT_WRITE: assert property (@(posedge clk) disable iff (rst) // RULE_22
        mem_we |-> !((bp_ff == BP_HALF) && mem_wa[ADDR_W-1]))
        else $error("protected byte written");
    AST_STANDBY_Z: assert property (@(posedge clk) disable iff (rst) // RULE_13
        (cs_s2_ff && cs_d_ff) |-> so_oe_n)
        else $error("serial output driven while deselected");
    AST_PAGE_WRAP: assert property (@(posedge sck) disable iff (rst || cs_n) // RULE_23
        (hold_n && byte_end && phase_ff == PH_DATA && cmd_ff == CMD_WRITE
         && wr_ptr_ff == 5'h1f) |=> (wr_ptr_ff == 5'h00))
        else $error("page pointer did not wrap");

endmodule
`default_nettype wire

// ==== sim/see_host.sv ====
// Host SPI controller model that drives the serial link of the EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module see_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    logic mode3;
    int hold_at;
    logic hold_oe;
    initial begin
        mode3 = 1'b0;
        hold_at = 0;
        hold_oe = 1'b0;
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic start();
        sck = mode3;
        #20 cs_n = 1'b0;
        #20;
    endtask
    // Bit countdown across the frame; hold is entered when it reaches zero
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            hold_at--;
            if (hold_at == 0) begin
                #7 hold_n = 1'b0;
                // Stray clocks while suspended must shift nothing
                repeat (2) begin
                    #15 sck = 1'b1;
                    si = ~si;
                    hold_oe = so_oe_n;
                    #15 sck = 1'b0;
                end
                si = tx[i];
                #7 hold_n = 1'b1;
            end
            #15 sck = 1'b1;
            // A released line reads inverted, so a stale bit can never pass
            rx[i] = so_oe_n ? ~so : so;
            #15;
        end
    endtask
    task automatic stop();
        sck = mode3;
        #20 cs_n = 1'b1;
        si = ~si;
        #120;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench for the SPI serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module tb;
    import see_pkg::*;
    localparam int WCYC = 64;
    logic clk;
    logic rst;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
    logic so;
    logic so_oe_n;
    see_status_t status;
    int miscompares;
    int compares;
    logic [7:0] rxq[$];
    logic [7:0] v;

    always #12.5 clk = ~clk;

    see_eeprom_slave #(.WRITE_CYC_P(WCYC)) dut_u (
        .clk(clk),
        .rst(rst),
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .hold_n(hold_n),
        .wp_n(wp_n),
        .so(so),
        .so_oe_n(so_oe_n),
        .status(status)
    );
    see_host host_u (
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .hold_n(hold_n),
        .so(so),
        .so_oe_n(so_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic sync();
        @(posedge clk);
        #1;
    endtask
    // Sends the header bytes, then clocks nrx bytes back into rxq
    task automatic frame(input logic [7:0] tx[$], input int nrx);
        logic [7:0] b;
        rxq = {};
        sync();
        host_u.start();
        foreach (tx[i]) begin
            host_u.xfer(tx[i], b);
        end
        repeat (nrx) begin
            host_u.xfer(8'h00, b);
            rxq.push_back(b);
        end
        host_u.stop();
        sync();
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (status.busy !== 1'b0 && n < 1000) begin
            sync();
            n++;
        end
        if (n == 1000) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        wp_n = 1'b1;
        miscompares = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) sync();
        chk(status, 8'h00);
        chk({7'h00, so_oe_n}, 8'h01);
        frame('{8'h02, 8'h00, 8'h10, 8'h5a}, 0);
        chk(status, 8'h00);
        frame('{8'h0e}, 0);
        chk(status, 8'h02);
        frame('{8'h02, 8'h00, 8'h1e, 8'ha1, 8'hb2, 8'hc3}, 0);
        chk(status, 8'hff);
        frame('{8'h06}, 0);
        frame('{8'h05}, 1);
        chk(rxq[0], 8'hff);
        wait_idle();
        chk(status, 8'h00);
        chk({7'h00, so_oe_n}, 8'h01);
        $display("page write test done");
        // Mode 3 read across the top of the array lands on the wrapped byte
        host_u.mode3 = 1'b1;
        frame('{8'h03, 8'h00, 8'h1e}, 2);
        chk(rxq[0], 8'ha1);
        chk(rxq[1], 8'hb2);
        frame('{8'h0b, 8'h03, 8'hff}, 2);
        chk(rxq[1], 8'hc3);
        chk({7'h00, so_oe_n}, 8'h01);
        host_u.mode3 = 1'b0;
        $display("read test done");
        for (int k = 1; k < 4; k++) begin
            v = {4'h0, 2'(k), 2'h0};
            frame('{8'h06}, 0);
            frame('{8'h01, v}, 0);
            wait_idle();
            chk(status, v);
            v = 8'(8'h40 + k);
            frame('{8'h06}, 0);
            frame('{8'h02, 8'h00, 8'h00, v}, 0);
            wait_idle();
            frame('{8'h03, 8'h00, 8'h00}, 1);
            chk(rxq[0], (k == 3) ? 8'h42 : v);
        end
        $display("block protect test done");
        frame('{8'h06}, 0);
        frame('{8'h01, 8'h8c}, 0);
        wait_idle();
        chk(status, 8'h8c);
        wp_n = 1'b0;
        repeat (3) sync();
        frame('{8'h06}, 0);
        frame('{8'h01, 8'h00}, 0);
        wait_idle();
        chk(status, 8'h8c);
        wp_n = 1'b1;
        repeat (3) sync();
        frame('{8'h06}, 0);
        frame('{8'h01, 8'h00}, 0);
        wait_idle();
        chk(status, 8'h00);
        $display("hardware protect test done");
        frame('{8'h06}, 0);
        host_u.hold_at = 13;
        frame('{8'h05}, 1);
        chk(rxq[0], 8'h02);
        chk({7'h00, host_u.hold_oe}, 8'h01);
        frame('{8'h04}, 0);
        chk(status, 8'h00);
        $display("suspend test done");
        // Supply drop in mid-run: volatile state returns to its standby values
        frame('{8'h06}, 0);
        rst = 1'b1;
        repeat (3) sync();
        rst = 1'b0;
        repeat (4) sync();
        chk(status, 8'h00);
        chk({7'h00, so_oe_n}, 8'h01);
        $display("power drop test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
